// file: dv/ccph_host_model.sv
module ccph_host_model (
  input  wire logic                  sys_clk,
  output logic                       rx_valid,
  output ccph_pkg::ccph_frame_t      rx_frame,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire ccph_pkg::ccph_frame_t tx_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b0;
  end
  // Between frames the bus shows the inverse of the last frame, never a stale copy.
  task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_frame <= '{id: id, dlc: dlc, data: d};
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask
  // The lag stalls the host before it takes the response.
  task automatic fetch(input logic [7:0] dst, input int lag, output ccph_pkg::ccph_frame_t f,
                       output logic ok);
    int n;
    send({13'h0cea, dst, 8'h21}, 4'h3, 64'h00ef_00ff_ffff_ffff);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (tx_valid !== 1'b1 && n < 8);
    ok = tx_valid;
    repeat (lag) @(posedge sys_clk);
    tx_ready <= 1'b1;
    @(posedge sys_clk);
    f = tx_frame;
    tx_ready <= 1'b0;
  endtask
endmodule

// file: dv/ccph_sva.sv
module ccph_sva (
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire logic                  rx_valid,
  input wire ccph_pkg::ccph_frame_t rx_frame,
  input wire logic                  tx_valid,
  input wire logic                  tx_ready,
  input wire ccph_pkg::ccph_frame_t tx_frame,
  input wire logic                  msg1_go,
  input wire logic                  pos_enable,
  input wire logic                  pos_settling,
  input wire logic [9:0]            bitrate_kbps,
  input wire logic [7:0]            node_addr,
  input wire logic                  nvm_save,
  input wire logic                  reset_req,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    rx_valid && rx_frame.id[28:8] == {13'h0cea, node_addr} && rx_frame.data[0:2] == 24'h00_ef00
      && !tx_valid;
  endsequence
  sequence s_answer;
    tx_valid && tx_frame.dlc == 4'h8 && tx_frame.id[28:16] == 13'h0cef;
  endsequence
  a_req_answer: assert property (s_req |=> s_answer ##0
    tx_frame.id[15:0] == {$past(rx_frame.id[7:0]), $past(node_addr)}) else $error("no answer");
  a_resp_shape: assert property (tx_valid |-> s_answer) else $error("bad response");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("response not held");
  a_tx_done: assert property (tx_valid && tx_ready |=> !tx_valid) else $error("not released");
  a_baud_legal: assert property (bitrate_kbps == 10'h07d || bitrate_kbps == 10'h0fa
    || bitrate_kbps == 10'h1f4) else $error("bad bit rate");
  a_store_reset: assert property (nvm_save |-> reset_req ##1 !nvm_save)
    else $error("save without reset");
  a_addr_latch: assert property ($changed(node_addr) |-> reset_req)
    else $error("address changed early");
  a_settle_pos: assert property (pos_settling |-> pos_enable) else $error("settling alone");
  a_msg_gate: assert property (msg1_go |-> pos_enable) else $error("message before start");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("stray data");
endmodule

// file: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MS = 10;
  logic                  sys_clk = 1'b0;
  logic                  resetn, rx_valid, tx_valid, tx_ready, reg_wr, reg_rd;
  logic                  msg1_go, pos_enable, nvm_save, reset_req, msg2_go, pos_settling, term_on;
  ccph_pkg::ccph_frame_t rx_frame, tx_frame;
  ccph_pkg::ccph_cfg_t   nvm_data;
  logic signed [31:0]    phys_pitch, phys_roll, out_pitch, out_roll;
  logic [9:0]            bitrate_kbps;
  logic [7:0]            node_addr, cur;
  logic [3:0]            reg_addr;
  logic [31:0]           reg_wdata, reg_rdata, d;
  int                    n_errors, total_checks, n_rst, n_sav, cyc, lag, n, n_m2, t0;
  logic [7:0]            bc[4] = '{8'h03, 8'h04, 8'h05, 8'h06};
  logic [63:0]           bk[4] = '{64'h07d, 64'h0fa, 64'h1f4, 64'h1f4};
  logic [7:0]            rc[4] = '{8'h01, 8'h0a, 8'h64, 8'h07};
  logic [63:0]           ro[4] = '{64'h07b, 64'h4d2, 64'h3039, 64'h3039};

  always #12.5 sys_clk = ~sys_clk;

  // The firmware string is an arbitrary value chosen so that its byte order is visible.
  ccph_top #(.MS_CYCLES(MS), .FW_VERSION(32'h3132_3334)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame), .phys_pitch(phys_pitch),
    .phys_roll(phys_roll), .out_pitch(out_pitch), .out_roll(out_roll), .msg1_go(msg1_go),
    .msg2_go(msg2_go), .pos_enable(pos_enable), .pos_settling(pos_settling),
    .bitrate_kbps(bitrate_kbps), .term_on(term_on), .node_addr(node_addr),
    .nvm_save(nvm_save), .nvm_data(nvm_data),
    .reset_req(reset_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  ccph_host_model host_u (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame));

  always @(posedge sys_clk) begin
    if (resetn) cyc++;
    if (reset_req === 1'b1) n_rst++;
    if (nvm_save === 1'b1) n_sav++;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic stl;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic rg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wf(input logic [7:0] ix, input logic [31:0] v);
    host_u.send({13'h0cef, cur, 8'h21}, 4'h8, {ix, v[7:0], v[15:8], v[23:16], v[31:24], 24'hff_ffff});
  endtask
  // An index-only frame selects what the next request returns.
  task automatic rdx(input logic [7:0] ix, input logic [63:0] exp);
    ccph_pkg::ccph_frame_t f;
    logic ok;
    host_u.send({13'h0cef, cur, 8'h21}, 4'h1, {ix, 56'hff_ffff_ffff_ffff});
    host_u.fetch(cur, lag, f, ok);
    lag = 3 - lag;
    chk({63'h0, ok}, 64'h1);
    chk(f.data, exp);
    chk({35'h0, f.id}, {35'h0, 13'h0cef, 8'h21, cur});
  endtask

  initial begin
    #750_000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog", $time);
    tally_and_finish;
  end

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    phys_pitch = 32'sh0000_3039;
    phys_roll = 32'sh0000_0000;
    cur = 8'hc0;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    stl;
    chk(node_addr, 64'hc0);
    rg_wr(4'h8, 32'h1234_5678);
    rg_rd(4'h8, d);
    chk(d, 64'h1234_5678);
    rg_wr(4'h4, 32'h0000_0005);
    rg_rd(4'h4, d);
    chk(d, 64'h1);
    rg_rd(4'h2, d);
    chk(d, 64'h0);
    rdx(8'h05, 64'h050a_00ff_ffff_ffff);
    rdx(8'h0f, 64'h0f01_ffff_ffff_ffff);
    rdx(8'h12, 64'h1278_5634_12ff_ffff);
    rdx(8'h10, 64'h1034_3332_31ff_ffff);
    for (int i = 0; i < 4; i++) begin
      wf(8'h08, {24'h0, bc[i]});
      stl;
      chk(bitrate_kbps, bk[i]);
      wf(8'h03, {24'h0, rc[i]});
      stl;
      chk(out_pitch, ro[i]);
    end
    rdx(8'h03, 64'h0364_00ff_ffff_ffff);
    phys_pitch <= 32'sh0000_03e8;
    wf(8'h0a, 32'h0000_1388);
    stl;
    chk(out_pitch, 64'h1388);
    wf(8'h0a, 32'h0000_4075);
    stl;
    chk(out_pitch, 64'h1388);
    wf(8'h0a, 32'h0000_4074);
    stl;
    chk(out_pitch, 64'h4074);
    wf(8'h0b, 32'h0000_2710);
    phys_roll <= 32'sh0000_2710;
    stl;
    chk(out_roll, 64'hffff_ffff_ffff_c180);
    rdx(8'h0c, 64'h0c8c_3c00_00ff_ffff);
    rdx(8'h0e, 64'h0e00_ffff_ffff_ffff);
    wf(8'h0e, 32'h0000_0001);
    stl;
    chk(term_on, 64'h1);
    wf(8'h05, 32'h0000_0014);
    rdx(8'h05, 64'h0514_00ff_ffff_ffff);
    rdx(8'h06, 64'h060a_00ff_ffff_ffff);
    chk(pos_enable, 64'h0);
    while (pos_enable !== 1'b1 && cyc < 14000) @(posedge sys_clk);
    chk(cyc >= 11990 && cyc <= 12010, 64'h1);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      n_m2 = 0;
      do begin
        @(posedge sys_clk);
        n++;
        if (msg2_go === 1'b1) n_m2++;
      end while (msg1_go !== 1'b1 && n < 5000);
    end
    chk(n, 64'hc8);
    chk(n_m2, 64'h2);
    wf(8'h07, 32'h0000_00c1);
    wf(8'h07, 32'h0000_00fe);
    stl;
    chk(node_addr, 64'hc0);
    rg_rd(4'hc, d);
    chk(d, 64'hc1c0);
    wf(8'hfa, 32'h0076_6173);
    stl;
    chk(n_rst, 64'h0);
    wf(8'hfa, ccph_pkg::KEY_STORE);
    stl;
    chk(n_sav + n_rst, 64'h2);
    chk(node_addr, 64'hc1);
    chk(nvm_data.addr, 64'hc1);
    cur = 8'hc1;
    wf(8'h09, 32'h0000_0001);
    rdx(8'h09, 64'h0901_ffff_ffff_ffff);
    wf(8'hfc, ccph_pkg::KEY_RESTOR);
    stl;
    cur = 8'hc0;
    chk(node_addr, 64'hc0);
    rdx(8'h05, 64'h050a_00ff_ffff_ffff);
    // A second start-up with fast start set early checks the shorter boot time.
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t0 = cyc;
    wf(8'h09, 32'h0000_0001);
    while (pos_enable !== 1'b1 && cyc - t0 < 8000) @(posedge sys_clk);
    chk(cyc - t0 >= 5990 && cyc - t0 <= 6010, 64'h1);
    chk(pos_settling, 64'h1);
    tally_and_finish;
  end
endmodule

bind ccph_top ccph_sva chk_u (.sys_clk(sys_clk), .resetn(resetn), .rx_valid(rx_valid),
  .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
  .msg1_go(msg1_go), .pos_enable(pos_enable), .pos_settling(pos_settling),
  .bitrate_kbps(bitrate_kbps), .node_addr(node_addr), .nvm_save(nvm_save),
  .reset_req(reset_req), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// file: rtl/ccph_pkg.sv
package ccph_pkg;
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOT_SLOW_MS  = 1200;
  localparam int unsigned BOOT_FAST_MS  = 600;
  localparam int unsigned SETTLE_END_MS = BOOT_FAST_MS + 600;

  // Frame identifiers (upper 13 bits of the 29-bit identifier), request bytes and fill byte.
  localparam logic [12:0] ID_WR_TOP  = 13'h0cef;
  localparam logic [12:0] ID_REQ_TOP = 13'h0cea;
  localparam logic [7:0]  REQ_B0     = 8'h00;
  localparam logic [7:0]  REQ_B1     = 8'hef;
  localparam logic [7:0]  REQ_B2     = 8'h00;
  localparam logic [7:0]  FILL       = 8'hff;

  // Parameter indexes.
  localparam logic [7:0] IX_DIR_P  = 8'h01;
  localparam logic [7:0] IX_DIR_R  = 8'h02;
  localparam logic [7:0] IX_RES_P  = 8'h03;
  localparam logic [7:0] IX_RES_R  = 8'h04;
  localparam logic [7:0] IX_CYC1   = 8'h05;
  localparam logic [7:0] IX_CYC2   = 8'h06;
  localparam logic [7:0] IX_ADDR   = 8'h07;
  localparam logic [7:0] IX_BAUD   = 8'h08;
  localparam logic [7:0] IX_FAST   = 8'h09;
  localparam logic [7:0] IX_PRE_P  = 8'h0a;
  localparam logic [7:0] IX_PRE_R  = 8'h0b;
  localparam logic [7:0] IX_OFS_P  = 8'h0c;
  localparam logic [7:0] IX_OFS_R  = 8'h0d;
  localparam logic [7:0] IX_TERM   = 8'h0e;
  localparam logic [7:0] IX_MODE   = 8'h0f;
  localparam logic [7:0] IX_FWVER  = 8'h10;
  localparam logic [7:0] IX_HWVER  = 8'h11;
  localparam logic [7:0] IX_SERIAL = 8'h12;
  localparam logic [7:0] IX_PCODE  = 8'h13;
  localparam logic [7:0] IX_NAME   = 8'h14;
  localparam logic [7:0] IX_STORE  = 8'hfa;
  localparam logic [7:0] IX_RESTOR = 8'hfc;
  localparam logic [31:0] KEY_STORE  = 32'h6576_6173; // Bytes 73 61 76 65 in frame order.
  localparam logic [31:0] KEY_RESTOR = 32'h6461_6f6c; // Bytes 6c 6f 61 64 in frame order.

  // Codes, limits and defaults.
  localparam logic [7:0]  RES_1       = 8'h01;
  localparam logic [7:0]  RES_10      = 8'h0a;
  localparam logic [7:0]  RES_100     = 8'h64;
  localparam logic [7:0]  BAUD_125    = 8'h03;
  localparam logic [7:0]  BAUD_250    = 8'h04;
  localparam logic [7:0]  BAUD_500    = 8'h05;
  localparam logic [7:0]  ADDR_MAX    = 8'hfd;
  localparam logic [7:0]  DEF_ADDR    = 8'hc0;
  localparam logic [15:0] DEF_CYCLE   = 16'h000a;
  localparam logic [31:0] PRESET_LIM  = 32'h0000_3c8c; // 155.00 degrees in 0.01 steps.
  localparam logic [31:0] HALF_TURN   = 32'h0000_4650; // 180.00 degrees.
  localparam logic [31:0] FULL_TURN   = 32'h0000_8ca0; // 360.00 degrees.
  localparam logic [2:0]  DEF_MODE    = 3'h1;

  // Software register map.
  localparam logic [3:0] RG_STATUS = 4'h0;
  localparam logic [3:0] RG_MODE   = 4'h4;
  localparam logic [3:0] RG_SERIAL = 4'h8;
  localparam logic [3:0] RG_ADDR   = 4'hc;

  typedef struct packed {
    logic [28:0]     id;
    logic [3:0]      dlc;
    logic [0:7][7:0] data;
  } ccph_frame_t;

  typedef struct packed {
    logic               dir_p;
    logic               dir_r;
    logic [7:0]         res_p;
    logic [7:0]         res_r;
    logic [15:0]        cyc1;
    logic [15:0]        cyc2;
    logic [7:0]         addr;
    logic [7:0]         baud;
    logic               fast;
    logic signed [31:0] pre_p;
    logic signed [31:0] pre_r;
    logic signed [31:0] ofs_p;
    logic signed [31:0] ofs_r;
    logic               term;
  } ccph_cfg_t;

  localparam ccph_cfg_t CFG_DEFAULT = '{
    dir_p: 1'b0, dir_r: 1'b0, res_p: RES_100, res_r: RES_100,
    cyc1: DEF_CYCLE, cyc2: DEF_CYCLE, addr: DEF_ADDR, baud: BAUD_250,
    fast: 1'b0, pre_p: 32'sh0000_0000, pre_r: 32'sh0000_0000,
    ofs_p: 32'sh0000_0000, ofs_r: 32'sh0000_0000, term: 1'b0};
endpackage

// file: rtl/ccph_top.sv
// Local design decisions: the register addresses and the strobed register port.
module ccph_top #(
  parameter int unsigned  MS_CYCLES  = ccph_pkg::MS_CYCLES,
  parameter logic [31:0]  FW_VERSION = 32'h3030_2e31, // Arbitrary value.
  parameter logic [47:0]  HW_VERSION = 48'h3130_5645_5248, // Arbitrary value.
  parameter logic [31:0]  PROD_CODE  = 32'h3030_3058, // Arbitrary value.
  parameter logic [23:0]  DEV_NAME   = 24'h5458_4e // Arbitrary value.
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  rx_valid,
  input  wire ccph_pkg::ccph_frame_t rx_frame,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output ccph_pkg::ccph_frame_t      tx_frame,
  input  wire logic signed [31:0]    phys_pitch,
  input  wire logic signed [31:0]    phys_roll,
  output logic signed [31:0]         out_pitch,
  output logic signed [31:0]         out_roll,
  output logic                       msg1_go,
  output logic                       msg2_go,
  output logic                       pos_enable,
  output logic                       pos_settling,
  output logic [9:0]                 bitrate_kbps,
  output logic                       term_on,
  output logic [7:0]                 node_addr,
  output logic                       nvm_save,
  output ccph_pkg::ccph_cfg_t        nvm_data,
  output logic                       reset_req,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata
);

  typedef enum logic [1:0] {
    CCPH_IDLE = 2'b01,
    CCPH_SEND = 2'b10
  } ccph_tx_state_t;

  ccph_pkg::ccph_cfg_t   cfg_q;
  ccph_pkg::ccph_frame_t tx_q;
  ccph_tx_state_t        txs_q;
  logic [7:0]            addr_q;
  logic [7:0]            sel_idx_q;
  logic [2:0]            mode_q;
  logic [31:0]           serial_q;
  logic [31:0]           rdata_q;
  logic                  save_q;
  logic                  rst_req_q;
  logic [15:0]           div_q;
  logic                  ms_tick;
  logic [10:0]           boot_ms_q;
  logic [15:0]           cyc1_cnt_q;
  logic [15:0]           cyc2_cnt_q;
  logic                  go1_q;
  logic                  go2_q;
  logic signed [31:0]    out_p_q;
  logic signed [31:0]    out_r_q;

  logic                  wr_hit;
  logic                  req_hit;
  logic [7:0]            w_idx;
  logic [7:0]            w_b1;
  logic [15:0]           w_u16;
  logic signed [31:0]    w_s32;
  logic signed [31:0]    pre_diff;
  logic                  pre_ok;

  function automatic logic res_valid(input logic [7:0] code);
    return code == ccph_pkg::RES_1 || code == ccph_pkg::RES_10 || code == ccph_pkg::RES_100;
  endfunction

  function automatic logic signed [31:0] abs32(input logic signed [31:0] v);
    return (v < 0) ? -v : v;
  endfunction

  // Adds offset and direction, keeps the result inside -180 .. +180 and scales it.
  function automatic logic signed [31:0] angle_out(input logic signed [31:0] phys,
                                                   input logic signed [31:0] ofs,
                                                   input logic               dir,
                                                   input logic [7:0]         res);
    logic signed [31:0] s;
    s = phys + ofs;
    if (s >= $signed(ccph_pkg::HALF_TURN)) begin
      s = s - $signed(ccph_pkg::FULL_TURN);
    end else if (s < -$signed(ccph_pkg::HALF_TURN)) begin
      s = s + $signed(ccph_pkg::FULL_TURN);
    end
    if (dir) begin
      s = -s;
    end
    case (res)
      ccph_pkg::RES_1:  s = s / 100;
      ccph_pkg::RES_10: s = s / 10;
      default:          s = s;
    endcase
    return s;
  endfunction

  // Payload of a response: value bytes least significant first, unused bytes filled.
  function automatic logic [0:6][7:0] resp_value(input logic [7:0]          idx,
                                                 input ccph_pkg::ccph_cfg_t c,
                                                 input logic [2:0]          mode,
                                                 input logic [31:0]         serial);
    logic [0:6][7:0] v;
    v = {7{ccph_pkg::FILL}};
    case (idx)
      ccph_pkg::IX_DIR_P:  v[0] = {7'h00, c.dir_p};
      ccph_pkg::IX_DIR_R:  v[0] = {7'h00, c.dir_r};
      ccph_pkg::IX_RES_P: begin
        v[0] = c.res_p;
        v[1] = 8'h00;
      end
      ccph_pkg::IX_RES_R: begin
        v[0] = c.res_r;
        v[1] = 8'h00;
      end
      ccph_pkg::IX_CYC1: begin
        v[0] = c.cyc1[7:0];
        v[1] = c.cyc1[15:8];
      end
      ccph_pkg::IX_CYC2: begin
        v[0] = c.cyc2[7:0];
        v[1] = c.cyc2[15:8];
      end
      ccph_pkg::IX_ADDR:   v[0] = c.addr;
      ccph_pkg::IX_BAUD:   v[0] = c.baud;
      ccph_pkg::IX_FAST:   v[0] = {7'h00, c.fast};
      ccph_pkg::IX_PRE_P:  v[0:3] = {<<8{c.pre_p}};
      ccph_pkg::IX_PRE_R:  v[0:3] = {<<8{c.pre_r}};
      ccph_pkg::IX_OFS_P:  v[0:3] = {<<8{c.ofs_p}};
      ccph_pkg::IX_OFS_R:  v[0:3] = {<<8{c.ofs_r}};
      ccph_pkg::IX_TERM:   v[0] = {7'h00, c.term};
      ccph_pkg::IX_MODE:   v[0] = {5'h00, mode};
      ccph_pkg::IX_FWVER:  v[0:3] = {<<8{FW_VERSION}};
      ccph_pkg::IX_HWVER:  v[0:5] = {<<8{HW_VERSION}};
      ccph_pkg::IX_SERIAL: v[0:3] = {<<8{serial}};
      ccph_pkg::IX_PCODE:  v[0:3] = {<<8{PROD_CODE}};
      ccph_pkg::IX_NAME:   v[0:2] = {<<8{DEV_NAME}};
      default:             v = {7{ccph_pkg::FILL}};
    endcase
    return v;
  endfunction

  // Frame decode. Frames are addressed to the active address, never the pending one.
  assign wr_hit  = rx_valid && rx_frame.id[28:16] == ccph_pkg::ID_WR_TOP
                   && rx_frame.id[15:8] == addr_q;
  assign req_hit = rx_valid && rx_frame.id[28:16] == ccph_pkg::ID_REQ_TOP
                   && rx_frame.id[15:8] == addr_q
                   && rx_frame.data[0] == ccph_pkg::REQ_B0
                   && rx_frame.data[1] == ccph_pkg::REQ_B1
                   && rx_frame.data[2] == ccph_pkg::REQ_B2;
  assign w_idx    = rx_frame.data[0];
  assign w_b1     = rx_frame.data[1];
  assign w_u16    = {rx_frame.data[2], rx_frame.data[1]};
  assign w_s32    = {rx_frame.data[4], rx_frame.data[3], rx_frame.data[2], rx_frame.data[1]};
  assign pre_diff = (w_idx == ccph_pkg::IX_PRE_P) ? w_s32 - phys_pitch : w_s32 - phys_roll;
  assign pre_ok   = abs32(pre_diff) <= $signed(ccph_pkg::PRESET_LIM);

  // Parameter writes, store and restore.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= ccph_pkg::CFG_DEFAULT;
    end else if (wr_hit && rx_frame.dlc > 4'h1) begin
      case (w_idx)
        ccph_pkg::IX_DIR_P: if (w_b1 <= 8'h01) cfg_q.dir_p <= w_b1[0];
        ccph_pkg::IX_DIR_R: if (w_b1 <= 8'h01) cfg_q.dir_r <= w_b1[0];
        ccph_pkg::IX_RES_P: if (res_valid(w_b1)) cfg_q.res_p <= w_b1;
        ccph_pkg::IX_RES_R: if (res_valid(w_b1)) cfg_q.res_r <= w_b1;
        ccph_pkg::IX_CYC1:  cfg_q.cyc1 <= w_u16;
        ccph_pkg::IX_CYC2:  cfg_q.cyc2 <= w_u16;
        ccph_pkg::IX_ADDR:  if (w_b1 <= ccph_pkg::ADDR_MAX) cfg_q.addr <= w_b1;
        ccph_pkg::IX_BAUD: begin
          if (w_b1 >= ccph_pkg::BAUD_125 && w_b1 <= ccph_pkg::BAUD_500) begin
            cfg_q.baud <= w_b1;
          end
        end
        ccph_pkg::IX_FAST:  if (w_b1 <= 8'h01) cfg_q.fast <= w_b1[0];
        ccph_pkg::IX_PRE_P: begin
          if (pre_ok) begin
            cfg_q.pre_p <= w_s32;
            cfg_q.ofs_p <= pre_diff;
          end
        end
        ccph_pkg::IX_PRE_R: begin
          if (pre_ok) begin
            cfg_q.pre_r <= w_s32;
            cfg_q.ofs_r <= pre_diff;
          end
        end
        ccph_pkg::IX_TERM:  if (w_b1 <= 8'h01) cfg_q.term <= w_b1[0];
        ccph_pkg::IX_RESTOR: begin
          if (w_s32 == ccph_pkg::KEY_RESTOR) begin
            cfg_q <= ccph_pkg::CFG_DEFAULT;
          end
        end
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Active address follows the written one only when the configuration is committed.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= ccph_pkg::DEF_ADDR;
    end else if (wr_hit && w_idx == ccph_pkg::IX_STORE && w_s32 == ccph_pkg::KEY_STORE) begin
      addr_q <= cfg_q.addr;
    end else if (wr_hit && w_idx == ccph_pkg::IX_RESTOR
                 && w_s32 == ccph_pkg::KEY_RESTOR) begin
      addr_q <= ccph_pkg::DEF_ADDR;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      save_q    <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      save_q    <= wr_hit && w_idx == ccph_pkg::IX_STORE
                   && w_s32 == ccph_pkg::KEY_STORE;
      rst_req_q <= wr_hit && ((w_idx == ccph_pkg::IX_STORE && w_s32 == ccph_pkg::KEY_STORE)
                   || (w_idx == ccph_pkg::IX_RESTOR
                   && w_s32 == ccph_pkg::KEY_RESTOR));
    end
  end

  // Any write frame with an index from IX_DIR_P to IX_NAME also selects what the next read request returns.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sel_idx_q <= ccph_pkg::IX_DIR_P;
    end else if (wr_hit && w_idx >= ccph_pkg::IX_DIR_P && w_idx <= ccph_pkg::IX_NAME) begin
      sel_idx_q <= w_idx;
    end
  end

  // Response frame. A request that arrives while one is still waiting is dropped.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txs_q <= CCPH_IDLE;
      tx_q  <= '0;
    end else begin
      case (txs_q)
        CCPH_IDLE: begin
          if (req_hit) begin
            tx_q.id   <= {ccph_pkg::ID_WR_TOP, rx_frame.id[7:0], addr_q};
            tx_q.dlc  <= 4'h8;
            tx_q.data <= {sel_idx_q, resp_value(sel_idx_q, cfg_q, mode_q, serial_q)};
            txs_q     <= CCPH_SEND;
          end
        end
        CCPH_SEND: if (tx_ready) txs_q <= CCPH_IDLE;
        default: txs_q <= CCPH_IDLE;
      endcase
    end
  end

  // Millisecond enable.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 16'h0000;
    end else if (ms_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign ms_tick = div_q == 16'(MS_CYCLES - 1);

  // Start-up timer runs until the settling window of the fast start has passed.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boot_ms_q <= 11'h000;
    end else if (ms_tick && boot_ms_q < 11'(ccph_pkg::SETTLE_END_MS)) begin
      boot_ms_q <= boot_ms_q + 11'h001;
    end
  end
  assign pos_enable   = cfg_q.fast ? boot_ms_q >= 11'(ccph_pkg::BOOT_FAST_MS)
                        : boot_ms_q >= 11'(ccph_pkg::BOOT_SLOW_MS);
  assign pos_settling = cfg_q.fast && pos_enable
                        && boot_ms_q < 11'(ccph_pkg::SETTLE_END_MS);

  // Message cadence. A cycle time of zero stops that message.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cyc1_cnt_q <= 16'h0000;
      go1_q      <= 1'b0;
    end else begin
      go1_q <= 1'b0;
      if (ms_tick && pos_enable && cfg_q.cyc1 != 16'h0000) begin
        if (cyc1_cnt_q + 16'h0001 >= cfg_q.cyc1) begin
          cyc1_cnt_q <= 16'h0000;
          go1_q      <= 1'b1;
        end else begin
          cyc1_cnt_q <= cyc1_cnt_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cyc2_cnt_q <= 16'h0000;
      go2_q      <= 1'b0;
    end else begin
      go2_q <= 1'b0;
      if (ms_tick && pos_enable && cfg_q.cyc2 != 16'h0000) begin
        if (cyc2_cnt_q + 16'h0001 >= cfg_q.cyc2) begin
          cyc2_cnt_q <= 16'h0000;
          go2_q      <= 1'b1;
        end else begin
          cyc2_cnt_q <= cyc2_cnt_q + 16'h0001;
        end
      end
    end
  end

  // The pitch input of a dual-axis unit is already folded at 90 degrees, so adding the
  // offset afterwards leaves the slope change at the same physical orientation.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_p_q <= 32'sh0000_0000;
      out_r_q <= 32'sh0000_0000;
    end else begin
      out_p_q <= angle_out(phys_pitch, cfg_q.ofs_p, cfg_q.dir_p, cfg_q.res_p);
      out_r_q <= angle_out(phys_roll, cfg_q.ofs_r, cfg_q.dir_r, cfg_q.res_r);
    end
  end

  // Software registers.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q   <= ccph_pkg::DEF_MODE;
      serial_q <= 32'h0000_0000;
    end else if (reg_wr) begin
      if (reg_addr == ccph_pkg::RG_MODE && reg_wdata[2:0] >= 3'h1 && reg_wdata[2:0] <= 3'h4) begin
        mode_q <= reg_wdata[2:0];
      end
      if (reg_addr == ccph_pkg::RG_SERIAL) begin
        serial_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ccph_pkg::RG_STATUS: rdata_q <= {28'h000_0000, txs_q == CCPH_SEND,
                                         cfg_q.addr != addr_q, pos_settling, pos_enable};
        ccph_pkg::RG_MODE:   rdata_q <= {29'h0000_0000, mode_q};
        ccph_pkg::RG_SERIAL: rdata_q <= serial_q;
        ccph_pkg::RG_ADDR:   rdata_q <= {16'h0000, cfg_q.addr, addr_q};
        default:             rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  always_comb begin
    case (cfg_q.baud)
      ccph_pkg::BAUD_125: bitrate_kbps = 10'd125;
      ccph_pkg::BAUD_500: bitrate_kbps = 10'd500;
      default:            bitrate_kbps = 10'd250;
    endcase
  end

  assign tx_valid     = txs_q == CCPH_SEND;
  assign tx_frame     = tx_q;
  assign out_pitch    = out_p_q;
  assign out_roll     = out_r_q;
  assign msg1_go      = go1_q;
  assign msg2_go      = go2_q;
  assign term_on      = cfg_q.term;
  assign node_addr    = addr_q;
  assign nvm_save     = save_q;
  assign nvm_data     = cfg_q;
  assign reset_req    = rst_req_q;
  assign reg_rdata    = rdata_q;

endmodule
